// ==== rtl/tpc_pkg.sv ====
// Constants shared by the capture/compare timer and its self-checking bench.
// Assumes a 32-bit AXI4-Lite register port with byte addresses.
package tpc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          NUM_CH     = 4;
  localparam int          CNT_W      = 16;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_OPT    = 8'h04;
  localparam logic [7:0]  OFS_CNT    = 8'h08;
  localparam logic [7:0]  OFS_EDGE   = 8'h0C;
  localparam logic [7:0]  OFS_MATCH0 = 8'h10;
  localparam logic [7:0]  OFS_MATCH1 = 8'h14;
  localparam logic [7:0]  OFS_MATCH2 = 8'h18;
  localparam logic [7:0]  OFS_MATCH3 = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_CE_BIT   = 7;
  localparam int          OPT_CAP_LSB   = 0;
  localparam int          OPT_WRAP_BIT  = 8;
  localparam int          OPT_PEND_BIT  = 9;
  localparam logic [2:0]  MODE_PWM      = 3'h4;
  localparam logic [2:0]  MODE_FREE     = 3'h5;
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ==== rtl/tpc_capture_edge.sv ====
// Capture pin synchroniser and per-channel edge detector.
// Assumes pins are asynchronous to aclk; edge select is two bits per channel.
module tpc_capture_edge #(
  parameter int N = 4
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic [N-1:0]   pin_in,
  input  wire logic [2*N-1:0] edge_sel,
  output logic      [N-1:0]   edge_pulse
);

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] last;
  } tpc_edge_s;

  tpc_edge_s st;
  tpc_edge_s next_st;

  always_comb begin
    next_st      = st;
    next_st.meta = pin_in;
    next_st.sync = st.meta;
    next_st.last = st.sync;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Bit 0 of a pair picks rising edges, bit 1 falling edges
  always_comb begin
    for (int i = 0; i < N; i++) begin
      edge_pulse[i] = (edge_sel[2*i]   &  st.sync[i] & ~st.last[i]) |
                      (edge_sel[2*i+1] & ~st.sync[i] &  st.last[i]);
    end
  end

endmodule

// ==== rtl/tpc_timer.sv ====
// 16-bit capture/compare timer with PWM and free-running modes, AXI4-Lite slave.
// Assumes one 200 MHz clock; capture pins are asynchronous and synchronised here.
//
// Overview of operation
// - PWM: buffers load at start; later updates only after channel 1 match register was written.
// - After that write, all buffers load when counter clears; compares use buffers.
// - Width zero keeps that PWM output inactive: 0% duty.
// - Width equal period plus one keeps output active; impossible with period FFFF.
// - PWM: channel k event when counter equals its buffered width.
// - Mode 101 selects free-running; counting begins when count enable is set.
// - Free-running: capture select bit makes each channel capture or compare.
// - Free-running compare: count enable inverts all four outputs at once.
// - Free-running compare match raises channel event and toggles its output.
// - Free-running: after FFFF, wrap event, counter to zero, wrap flag set.
// - Wrap flag stays set until software clears it; hardware never clears it.
// - Free-running compare registers are unbuffered and used at the next compare.
// - Capture edge latches the counter into the channel register with an event.
// - Mode 100 selects PWM; waveforms on outputs 1 to 3 once enabled.
// - PWM period is channel 0 value plus one counts; width is channel value.
// - PWM: channel 0 event on the count after period match, counter cleared.
module tpc_timer #(
  parameter int COUNT_DIV = 1
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [tpc_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [tpc_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [tpc_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [tpc_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic [tpc_pkg::NUM_CH-1:0]  capture_in_pin,
  output logic [tpc_pkg::NUM_CH-1:0]       chan_out_pin,
  output logic [tpc_pkg::NUM_CH-1:0]       chan_event_irq,
  output logic                             wrap_irq
);

  localparam int DIV_W = (COUNT_DIV > 1) ? $clog2(COUNT_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(COUNT_DIV - 1);

  typedef struct packed {
    logic [3:0][15:0]                match;
    logic [3:0][15:0]                shadow_match_buf;
    logic [15:0]                     cnt;
    logic [DIV_W-1:0]                div;
    logic                            count_enable_bit;
    logic [2:0]                      op_mode_field;
    logic [3:0]                      cap_select;
    logic [7:0]                      edge_sel;
    logic                            wrap_flag;
    logic                            xfer_pend;
    logic                            running;
    logic [3:0]                      pins;
    logic [3:0]                      ch_irq;
    logic                            wrap_irq;
    logic                            aw_have;
    logic [tpc_pkg::ADDR_W-1:0]      aw_addr;
    logic                            w_have;
    logic [31:0]                     w_data;
    logic [3:0]                      w_strb;
    logic                            awready;
    logic                            wready;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            arready;
    logic                            rvalid;
    logic [31:0]                     rdata;
    logic [1:0]                      rresp;
  } tpc_state_s;

  tpc_state_s st;
  tpc_state_s next_st;

  logic [3:0]  cap_edge;
  logic        pwm;
  logic        frm;
  logic        start;
  logic        tick;
  logic        do_write;
  logic        opt_write;
  logic [7:0]  wr_addr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'h0};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  tpc_capture_edge #(
    .N          (tpc_pkg::NUM_CH)
  ) tpc_capture_edge_i (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin_in     (capture_in_pin),
    .edge_sel   (st.edge_sel),
    .edge_pulse (cap_edge)
  );

  assign pwm       = (st.op_mode_field == tpc_pkg::MODE_PWM);
  assign frm       = (st.op_mode_field == tpc_pkg::MODE_FREE);
  assign start     = st.count_enable_bit && !st.running && (pwm || frm);
  assign tick      = st.count_enable_bit && st.running && (st.div == '0);
  assign do_write  = st.aw_have && st.w_have && !st.bvalid;
  assign wr_addr   = word_addr(st.aw_addr);
  assign opt_write = do_write && (wr_addr == tpc_pkg::OFS_OPT);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] cur;
    logic [15:0] nc;
    logic [7:0]  rd_addr;
    cur     = '0;
    nc      = st.cnt;
    rd_addr = word_addr(araddr);
    next_st = st;
    next_st.ch_irq   = '0;
    next_st.wrap_irq = 1'b0;

    // Write address and data may arrive in either order
    if (awvalid && st.awready) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && st.wready) begin
      next_st.w_have = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    next_st.bvalid = st.bvalid && !bready;

    // Counter and waveform engine
    if (!st.count_enable_bit) begin
      next_st.cnt     = tpc_pkg::CNT_ZERO;
      next_st.div     = '0;
      next_st.running = 1'b0;
    end else if (start) begin
      next_st.running = 1'b1;
      next_st.cnt     = tpc_pkg::CNT_ZERO;
      if (pwm) begin
        next_st.shadow_match_buf = st.match;
        next_st.xfer_pend        = 1'b0;
        next_st.pins[0]          = 1'b1;
        for (int k = 1; k < 4; k++) begin
          next_st.pins[k] = (tpc_pkg::CNT_ZERO < st.match[k]);
        end
      end else begin
        next_st.pins = ~st.pins;
      end
    end else if (st.running) begin
      next_st.div = (st.div == DIV_LAST) ? '0 : st.div + 1'b1;
    end

    if (tick && pwm) begin
      if (st.cnt == st.shadow_match_buf[0]) begin
        nc                = tpc_pkg::CNT_ZERO;
        next_st.ch_irq[0] = 1'b1;
        next_st.pins[0]   = ~st.pins[0];
        if (st.xfer_pend) begin
          next_st.shadow_match_buf = st.match;
          next_st.xfer_pend        = 1'b0;
        end
      end else begin
        nc = st.cnt + 1'b1;
      end
      next_st.cnt = nc;
      for (int k = 1; k < 4; k++) begin
        next_st.ch_irq[k] = (nc == next_st.shadow_match_buf[k]);
        // Active from clear until the width match; zero never active
        next_st.pins[k]   = (nc < next_st.shadow_match_buf[k]);
      end
    end

    // Register writes land before the free-running compare so a new value is used at once
    if (do_write) begin
      next_st.aw_have = 1'b0;
      next_st.w_have  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = tpc_pkg::RESP_OKAY;
      unique case (wr_addr)
        tpc_pkg::OFS_CTRL: begin
          cur = merge({24'h0, st.count_enable_bit, 4'h0, st.op_mode_field}, st.w_data, st.w_strb);
          next_st.count_enable_bit = cur[tpc_pkg::CTRL_CE_BIT];
          next_st.op_mode_field    = cur[tpc_pkg::CTRL_MODE_LSB +: 3];
        end
        tpc_pkg::OFS_OPT: begin
          cur = merge({23'h0, st.wrap_flag, 4'h0, st.cap_select}, st.w_data, st.w_strb);
          next_st.cap_select = cur[tpc_pkg::OPT_CAP_LSB +: 4];
          // Writing 0 clears the flag, writing 1 leaves it alone
          next_st.wrap_flag  = st.wrap_flag && cur[tpc_pkg::OPT_WRAP_BIT];
        end
        tpc_pkg::OFS_EDGE: begin
          cur = merge({24'h0, st.edge_sel}, st.w_data, st.w_strb);
          next_st.edge_sel = cur[7:0];
        end
        tpc_pkg::OFS_MATCH0, tpc_pkg::OFS_MATCH1, tpc_pkg::OFS_MATCH2, tpc_pkg::OFS_MATCH3: begin
          cur = merge({16'h0, st.match[wr_addr[3:2]]}, st.w_data, st.w_strb);
          next_st.match[wr_addr[3:2]] = cur[15:0];
          next_st.xfer_pend = next_st.xfer_pend || (wr_addr == tpc_pkg::OFS_MATCH1);
        end
        tpc_pkg::OFS_CNT: next_st.bresp = tpc_pkg::RESP_OKAY;
        default:          next_st.bresp = tpc_pkg::RESP_SLVERR;
      endcase
    end

    if (tick && frm) begin
      nc = st.cnt + 1'b1;
      next_st.cnt = nc;
      if (st.cnt == tpc_pkg::CNT_MAX) begin
        next_st.wrap_irq  = 1'b1;
        next_st.wrap_flag = 1'b1;
      end
      for (int m = 0; m < 4; m++) begin
        if (!st.cap_select[m] && nc == next_st.match[m]) begin
          next_st.ch_irq[m] = 1'b1;
          next_st.pins[m]   = ~st.pins[m];
        end
      end
    end
    // Capture last so a hardware capture beats a same-cycle register write
    if (frm && st.running) begin
      for (int m = 0; m < 4; m++) begin
        if (st.cap_select[m] && cap_edge[m]) begin
          next_st.match[m]  = st.cnt;
          next_st.ch_irq[m] = 1'b1;
        end
      end
    end
    // Read channel
    next_st.rvalid = st.rvalid && !rready;
    if (arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = tpc_pkg::RESP_OKAY;
      unique case (rd_addr)
        tpc_pkg::OFS_CTRL:   next_st.rdata = {24'h0, st.count_enable_bit, 4'h0, st.op_mode_field};
        tpc_pkg::OFS_OPT:    next_st.rdata = {22'h0, st.xfer_pend, st.wrap_flag, 4'h0, st.cap_select};
        tpc_pkg::OFS_CNT:    next_st.rdata = {16'h0, st.cnt};
        tpc_pkg::OFS_EDGE:   next_st.rdata = {24'h0, st.edge_sel};
        tpc_pkg::OFS_MATCH0, tpc_pkg::OFS_MATCH1, tpc_pkg::OFS_MATCH2, tpc_pkg::OFS_MATCH3: begin
          next_st.rdata = {16'h0, st.match[rd_addr[3:2]]};
        end
        default: begin
          next_st.rdata = '0;
          next_st.rresp = tpc_pkg::RESP_SLVERR;
        end
      endcase
    end

    next_st.awready = !next_st.aw_have && !next_st.bvalid;
    next_st.wready  = !next_st.w_have && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign awready        = st.awready;
  assign wready         = st.wready;
  assign bvalid         = st.bvalid;
  assign bresp          = st.bresp;
  assign arready        = st.arready;
  assign rvalid         = st.rvalid;
  assign rdata          = st.rdata;
  assign rresp          = st.rresp;
  assign chan_out_pin   = st.pins;
  assign chan_event_irq = st.ch_irq;
  assign wrap_irq       = st.wrap_irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pwm_clear;
    tick && pwm && (st.cnt == st.shadow_match_buf[0]);
  endsequence
  sequence s_wrap_seen;
    wrap_irq && (st.cnt == tpc_pkg::CNT_ZERO) && st.wrap_flag;
  endsequence
  a_idle_no_events: assert property (!st.running |=> (chan_event_irq == '0) && !wrap_irq)
    else $error("event raised while timer not running");
  a_wrap_event: assert property (tick && frm && st.cnt == tpc_pkg::CNT_MAX |=> s_wrap_seen)
    else $error("free-running wrap not signalled");
  a_flag_sticky: assert property (st.wrap_flag && !opt_write |=> st.wrap_flag)
    else $error("wrap flag dropped without software clear");
  a_pwm_clear_irq: assert property (s_pwm_clear |=> chan_event_irq[0] && st.cnt == tpc_pkg::CNT_ZERO)
    else $error("period match did not clear counter");
  a_buffer_gated: assert property (s_pwm_clear ##0 !st.xfer_pend |=> $stable(st.shadow_match_buf))
    else $error("buffer changed without channel 1 write");
  a_buffer_load: assert property (s_pwm_clear ##0 st.xfer_pend |=> st.shadow_match_buf == $past(st.match))
    else $error("buffer not loaded at clear");
  a_zero_duty: assert property (pwm && st.running && st.shadow_match_buf[1] == '0 && !st.xfer_pend
                                |=> !chan_out_pin[1])
    else $error("zero width output went active");
  a_free_start: assert property (start && frm |=> chan_out_pin == ~$past(chan_out_pin))
    else $error("outputs not inverted at start");
  a_capture_latch: assert property (frm && st.running && st.cap_select[0] && cap_edge[0]
                                    |=> st.match[0] == $past(st.cnt) && chan_event_irq[0])
    else $error("capture did not latch counter");

endmodule

// ==== tb/tpc_pin_model.sv ====
// Far-side model of the capture pins: drives short pulses on request.
// Assumes the bench calls pulse() right after a rising edge of aclk.
module tpc_pin_model (
  input  wire logic       aclk,
  output logic      [3:0] capture_in_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle low, as if each pin had a pull-down
  initial capture_in_pin = 4'h0;

  // ----------------------------------------------------------------
  // Pulse long enough to pass the two-flop synchroniser
  // ----------------------------------------------------------------
  task automatic pulse(input int ch);
    capture_in_pin[ch] <= 1'b1;
    repeat (4) @(posedge aclk);
    capture_in_pin[ch] <= 1'b0;
  endtask
endmodule

// ==== tb/tpc_timer_bench.sv ====
// Self-checking bench of the capture/compare timer over AXI4-Lite.
// Assumes the block's register map and bus latencies; COUNT_DIV is 1.
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tpc_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, capture_in_pin, chan_out_pin, chan_event_irq;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, wrap_irq;
  int          fails, compares;
  int          hi[4], ev[4];

  tpc_timer #(.COUNT_DIV(1)) tpc_timer_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .capture_in_pin(capture_in_pin), .chan_out_pin(chan_out_pin),
    .chan_event_irq(chan_event_irq), .wrap_irq(wrap_irq));

  tpc_pin_model tpc_pin_model_i (.aclk(aclk), .capture_in_pin(capture_in_pin));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Bus master tasks: enter and leave just after a rising edge
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 100);
    // bready stays up between writes: never lowered and raised in one step
    `CHK(n < 100, 1'b1)
    `CHK(bresp, tpc_pkg::RESP_OKAY)
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 100);
    `CHK(n < 100, 1'b1)
    rd = rdata;
    rs = rresp;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  // Counts high levels and event pulses over a span
  task automatic sample(input int cyc);
    hi = '{default: 0};
    ev = '{default: 0};
    repeat (cyc) begin
      @(posedge aclk);
      for (int k = 0; k < 4; k++) begin
        hi[k] += (chan_out_pin[k] === 1'b1);
        ev[k] += (chan_event_irq[k] === 1'b1);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_state();
    `CHK({chan_out_pin, chan_event_irq, wrap_irq}, 9'h000)
    axi_rd(tpc_pkg::OFS_CNT);
    `CHK(rd, 32'h0000_0000)
    axi_rd(tpc_pkg::OFS_OPT);
    `CHK(rd[8], 1'b0)
    axi_rd(8'h40);
    `CHK({rs, rd}, {tpc_pkg::RESP_SLVERR, 32'h0000_0000})
  endtask

  task automatic test_pwm();
    axi_wr(tpc_pkg::OFS_MATCH0, 32'h4);
    axi_wr(tpc_pkg::OFS_MATCH2, 32'h0);
    axi_wr(tpc_pkg::OFS_MATCH3, 32'h5);
    axi_wr(tpc_pkg::OFS_MATCH1, 32'h2);
    axi_wr(tpc_pkg::OFS_CTRL, 32'h84);
    repeat (10) @(posedge aclk);
    sample(50);
    `CHK(ev[0], 10)
    `CHK(hi[1], 20)
    `CHK(ev[1], 10)
    `CHK(hi[2], 0)
    `CHK(hi[3], 50)
    `CHK(ev[3], 0)
    // Width change alone must stay pending
    axi_wr(tpc_pkg::OFS_MATCH2, 32'h3);
    repeat (20) @(posedge aclk);
    sample(50);
    `CHK(hi[2], 0)
    axi_wr(tpc_pkg::OFS_MATCH1, 32'h2);
    // Several period matches pass before the next rewrite
    repeat (20) @(posedge aclk);
    sample(50);
    `CHK(hi[2], 30)
    `CHK(hi[1], 20)
    // Period-only change
    axi_wr(tpc_pkg::OFS_MATCH0, 32'h9);
    axi_wr(tpc_pkg::OFS_MATCH1, 32'h2);
    repeat (30) @(posedge aclk);
    sample(50);
    `CHK(ev[0], 5)
    `CHK(hi[1], 10)
    // Output 1 duty alone
    axi_wr(tpc_pkg::OFS_MATCH1, 32'h6);
    repeat (30) @(posedge aclk);
    sample(50);
    `CHK(hi[1], 30)
    `CHK(hi[2], 15)
    // All duties, channel 1 last and to zero
    axi_wr(tpc_pkg::OFS_MATCH2, 32'h8);
    axi_wr(tpc_pkg::OFS_MATCH3, 32'hA);
    axi_wr(tpc_pkg::OFS_MATCH1, 32'h0);
    repeat (30) @(posedge aclk);
    sample(50);
    `CHK(hi[1], 0)
    `CHK(hi[2], 40)
    `CHK(hi[3], 50)
  endtask

  task automatic test_free_compare();
    int n;
    axi_wr(tpc_pkg::OFS_MATCH0, 32'h8000);
    axi_wr(tpc_pkg::OFS_MATCH2, 32'h8000);
    axi_wr(tpc_pkg::OFS_MATCH3, 32'h8000);
    axi_wr(tpc_pkg::OFS_MATCH1, 32'h000A);
    axi_wr(tpc_pkg::OFS_CTRL, 32'h85);
    @(posedge aclk);
    `CHK(chan_out_pin, 4'hF)
    n = 0;
    while (!(chan_event_irq[1] === 1'b1) && n < 40) begin
      @(posedge aclk);
      n++;
    end
    `CHK(chan_event_irq[1], 1'b1)
    @(posedge aclk);
    `CHK(chan_out_pin, 4'hD)
    // Unbuffered rewrite must fire in the same pass of the counter
    axi_wr(tpc_pkg::OFS_MATCH1, 32'h0040);
    n = 0;
    while (!(chan_event_irq[1] === 1'b1) && n < 80) begin
      @(posedge aclk);
      n++;
    end
    `CHK(chan_event_irq[1], 1'b1)
  endtask

  task automatic test_wrap();
    int n;
    n = 0;
    while (!(wrap_irq === 1'b1) && n < 70000) begin
      @(posedge aclk);
      n++;
    end
    `CHK(wrap_irq, 1'b1)
    // Read is taken two edges after the wrap edge: counter has moved on to 1
    axi_rd(tpc_pkg::OFS_CNT);
    `CHK(rd[15:0], 16'h0001)
    repeat (50) @(posedge aclk);
    axi_rd(tpc_pkg::OFS_OPT);
    `CHK(rd[8], 1'b1)
    axi_wr(tpc_pkg::OFS_OPT, 32'h0);
    axi_rd(tpc_pkg::OFS_OPT);
    `CHK(rd[8], 1'b0)
  endtask

  task automatic test_capture();
    logic [15:0] c0;
    int          n;
    axi_wr(tpc_pkg::OFS_OPT, 32'h1);
    axi_wr(tpc_pkg::OFS_EDGE, 32'h1);
    axi_rd(tpc_pkg::OFS_CNT);
    c0 = rd[15:0];
    // Pin rises one edge after the count is sampled; two sync flops and the detector add three
    tpc_pin_model_i.pulse(0);
    n = 0;
    while (!(chan_event_irq[0] === 1'b1) && n < 30) begin
      @(posedge aclk);
      n++;
    end
    `CHK(chan_event_irq[0], 1'b1)
    axi_rd(tpc_pkg::OFS_MATCH0);
    `CHK(rd[15:0], c0 + 16'h0004)
  endtask

  // ----------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    fails = 0; compares = 0;
    aresetn = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    do_reset();
    test_reset_state();
    test_pwm();
    do_reset();
    test_free_compare();
    test_wrap();
    test_capture();
    complete_run();
  end

  // Wrap scenario alone needs about 65536 cycles
  initial begin
    repeat (90000) @(posedge aclk);
    fails++;
    complete_run();
  end
endmodule
